// >>> rtl/sgpbcd_pkg.sv
// Package of register offsets, field positions and reset values for the B/C/D port block
package sgpbcd_pkg;
    localparam int unsigned ADDR_W       = 4;              // Register address width
    localparam logic [3:0]  OFS_B_DATA   = 4'h1;           // Port B data latch
    localparam logic [3:0]  OFS_C_DATA   = 4'h2;           // Port C data latch
    localparam logic [3:0]  OFS_D_DATA   = 4'h3;           // Port D data latch
    localparam logic [3:0]  OFS_B_DIR    = 4'h5;           // Port B direction
    localparam logic [3:0]  OFS_C_DIR    = 4'h6;           // Port C direction
    localparam logic [3:0]  OFS_D_DIR    = 4'h7;           // Port D direction
    localparam logic [7:0]  DIR_RESET    = 8'h00;          // All pins input after reset
    localparam logic [7:0]  C_DATA_MASK  = 8'h3f;          // Six implemented port C bits
    localparam logic [7:0]  C_DIR_MASK   = 8'hbf;          // Bit 6 of port C direction unused
    localparam int unsigned CLK_OUT_POS  = 7;              // Clock-out enable position
    localparam int unsigned CLK_PIN_POS  = 2;              // Port C pin carrying clock out
    localparam int unsigned TA_CLK_POS   = 6;              // Port D pin for timer A clock
    localparam int unsigned TB_CLK_POS   = 4;              // Port D pin for timer B clock
    localparam logic [2:0]  PS_EXT_CLOCK = 3'h7;           // Prescale code choosing external pin
    localparam logic [4:0]  CH_B_FIRST   = 5'h00;          // First converter channel on port B
    localparam logic [4:0]  CH_D_FIRST   = 5'h08;          // First converter channel on port D
    localparam logic [4:0]  CH_D_LAST    = 5'h0e;          // Last converter channel on port D
endpackage : sgpbcd_pkg

// >>> rtl/sgpbcd_bit.sv
// One general-purpose port bit: pin drive and read-back selection
`timescale 1ns/1ps
module sgpbcd_bit (
    input  wire logic latch_i,       // Data latch value
    input  wire logic dir_i,         // Direction bit
    input  wire logic pin_i,         // Live pin level
    input  wire logic shared_i,      // Pin taken by converter or timer
    input  wire logic zero_in_i,     // Read zero when input and shared
    output wire logic pin_o,         // Value driven on pin
    output wire logic pin_oe_o,      // Output buffer enable
    output wire logic read_o         // Value seen by a data read
);
    // Buffer enabled by direction unless another function owns the pin
    assign pin_oe_o = dir_i & ~shared_i;                     // see R03
    assign pin_o    = latch_i;                               // see R03
    // Output reads latch, input reads pin or zero when shared
    assign read_o   = dir_i ? latch_i : (zero_in_i ? 1'b0 : pin_i); // see R05
endmodule : sgpbcd_bit

// >>> rtl/sgpbcd_top.sv
// Ports B, C and D with data latches, direction registers and shared pin functions
// Functional notes
// R01 - Converter pin reads zero when input
// R02 - Converter port B pins ignore direction drive
// R03 - Direction one drives latch, zero floats
// R04 - Reset clears all direction bits
// R05 - Read returns latch if output, else pin
// R06 - Data writes always update latch
// R07 - Reset leaves port C latches alone
// R08 - Port C has six bidirectional bits
// R09 - Clock-out enable drives clock on C2
// R10 - Clock-out overrides C2 direction, resets clear
// R11 - Seven port D pins are converter channels
// R12 - Timer pins read latch or zero
// R13 - Selected timer clock pin feeds timer
// R14 - Software writes latch before setting direction
// R15 - Data then direction registers, consecutive
// R16 - Unused port C bits read zero
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
module sgpbcd_top #(
    parameter int unsigned WIDTH = 8                       // Port width
) (
    input  wire logic                     MCLK_I,          // Bus clock, 25 MHz
    input  wire logic                     RESETN_I,        // Asynchronous reset, active low
    input  wire logic [3:0]               ADDR_I,          // Register address
    input  wire logic [7:0]               WDATA_I,         // Write data
    input  wire logic                     WR_I,            // Write strobe
    input  wire logic                     RD_I,            // Read strobe
    output logic      [7:0]               RDATA_O,         // Read data, cycle after strobe
    input  wire logic [4:0]               CONV_SEL_I,      // Converter channel select
    input  wire logic                     CONV_EN_I,       // Converter owns selected channel
    input  wire logic [2:0]               TA_PS_I,         // Timer A prescale select
    input  wire logic [2:0]               TB_PS_I,         // Timer B prescale select
    input  wire logic [WIDTH-1:0]         PB_I,            // Port B pin levels
    output wire logic [WIDTH-1:0]         PB_O,            // Port B pin drive
    output wire logic [WIDTH-1:0]         PB_OE_O,         // Port B output enables
    input  wire logic [5:0]               PC_I,            // Port C pin levels
    output wire logic [5:0]               PC_O,            // Port C pin drive
    output wire logic [5:0]               PC_OE_O,         // Port C output enables
    input  wire logic [WIDTH-1:0]         PD_I,            // Port D pin levels
    output wire logic [WIDTH-1:0]         PD_O,            // Port D pin drive
    output wire logic [WIDTH-1:0]         PD_OE_O,         // Port D output enables
    output wire logic                     TA_EXT_CLK_O,    // Timer A external clock from pin
    output wire logic                     TB_EXT_CLK_O     // Timer B external clock from pin
);
    // Registers
    logic [WIDTH-1:0] port_b_latch_q;                      // Port B latch, no reset
    logic [5:0]       port_c_latch_q;                      // Port C latch, no reset
    logic [WIDTH-1:0] port_d_latch_q;                      // Port D latch, no reset
    logic [WIDTH-1:0] port_b_dir_q;                        // Port B direction
    logic [5:0]       port_c_dir_q;                        // Port C direction
    logic             sys_clock_out_en_q;                  // Clock-out enable
    logic [WIDTH-1:0] port_d_dir_q;                        // Port D direction
    logic [7:0]       rdata_d;                             // Next read data

    // Address decode
    wire wr_b_data = WR_I & (ADDR_I == sgpbcd_pkg::OFS_B_DATA);   // see R15
    wire wr_c_data = WR_I & (ADDR_I == sgpbcd_pkg::OFS_C_DATA);   // see R15
    wire wr_d_data = WR_I & (ADDR_I == sgpbcd_pkg::OFS_D_DATA);   // see R15
    wire wr_b_dir  = WR_I & (ADDR_I == sgpbcd_pkg::OFS_B_DIR);    // see R15
    wire wr_c_dir  = WR_I & (ADDR_I == sgpbcd_pkg::OFS_C_DIR);    // see R15
    wire wr_d_dir  = WR_I & (ADDR_I == sgpbcd_pkg::OFS_D_DIR);    // see R15

    // Read strobes per register, watched by the checks at the end
    wire rd_b_data = RD_I & (ADDR_I == sgpbcd_pkg::OFS_B_DATA);   // see R15
    wire rd_c_data = RD_I & (ADDR_I == sgpbcd_pkg::OFS_C_DATA);   // see R15
    wire rd_d_data = RD_I & (ADDR_I == sgpbcd_pkg::OFS_D_DATA);   // see R15
    wire rd_b_dir  = RD_I & (ADDR_I == sgpbcd_pkg::OFS_B_DIR);    // see R15
    wire rd_c_dir  = RD_I & (ADDR_I == sgpbcd_pkg::OFS_C_DIR);    // see R15
    wire rd_d_dir  = RD_I & (ADDR_I == sgpbcd_pkg::OFS_D_DIR);    // see R15
    wire rd_mapped = rd_b_data | rd_c_data | rd_d_data
                   | rd_b_dir | rd_c_dir | rd_d_dir;              // Any register read

    // Converter ownership, one-hot per channel
    // Only one channel is converted at a time, so each mask has at most one bit set
    wire [4:0]       d_off   = CONV_SEL_I - sgpbcd_pkg::CH_D_FIRST;
    wire             b_hit   = CONV_EN_I & (CONV_SEL_I < sgpbcd_pkg::CH_D_FIRST);
    wire             d_hit   = CONV_EN_I & (CONV_SEL_I >= sgpbcd_pkg::CH_D_FIRST)
                               & (CONV_SEL_I <= sgpbcd_pkg::CH_D_LAST);       // see R11
    wire [WIDTH-1:0] b_conv  = b_hit ? (WIDTH'(1) << CONV_SEL_I[2:0]) : '0;   // see R01
    wire [WIDTH-1:0] d_conv  = d_hit ? (WIDTH'(1) << d_off[2:0]) : '0;        // see R11

    // Timer external clock selection
    // Any other prescale code leaves the pin as plain I/O
    wire ta_sel = (TA_PS_I == sgpbcd_pkg::PS_EXT_CLOCK);                      // see R13
    wire tb_sel = (TB_PS_I == sgpbcd_pkg::PS_EXT_CLOCK);                      // see R13
    wire [WIDTH-1:0] d_tim = (WIDTH'(ta_sel) << sgpbcd_pkg::TA_CLK_POS)
                           | (WIDTH'(tb_sel) << sgpbcd_pkg::TB_CLK_POS);      // see R12
    assign TA_EXT_CLK_O = ta_sel & PD_I[sgpbcd_pkg::TA_CLK_POS];              // see R13
    assign TB_EXT_CLK_O = tb_sel & PD_I[sgpbcd_pkg::TB_CLK_POS];              // see R13

    // Port C clock-out ownership
    // Enable bit forces pin C2 to output whatever its direction bit says
    wire [5:0] c_clk = 6'(sys_clock_out_en_q) << sgpbcd_pkg::CLK_PIN_POS;     // see R10

    // Per-bit read values and drive
    wire [WIDTH-1:0] b_rd;
    wire [5:0]       c_rd;
    wire [5:0]       c_pin;
    wire [5:0]       c_oe;
    wire [WIDTH-1:0] d_rd;
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bd
            // Port B: converter pin reads zero as input
            sgpbcd_bit u_b (
                .latch_i   (port_b_latch_q[g]),
                .dir_i     (port_b_dir_q[g]),
                .pin_i     (PB_I[g]),
                .shared_i  (b_conv[g]),                    // see R02
                .zero_in_i (b_conv[g]),                    // see R01
                .pin_o     (PB_O[g]),
                .pin_oe_o  (PB_OE_O[g]),
                .read_o    (b_rd[g])
            );
            // Port D: converter or timer pins read zero as input
            sgpbcd_bit u_d (
                .latch_i   (port_d_latch_q[g]),
                .dir_i     (port_d_dir_q[g]),
                .pin_i     (PD_I[g]),
                .shared_i  (d_conv[g] | d_tim[g]),         // see R12
                .zero_in_i (d_conv[g] | d_tim[g]),         // see R01
                .pin_o     (PD_O[g]),
                .pin_oe_o  (PD_OE_O[g]),
                .read_o    (d_rd[g])
            );
        end
        for (g = 0; g < 6; g++) begin : g_c
            // Port C: plain I/O bits
            sgpbcd_bit u_c (
                .latch_i   (port_c_latch_q[g]),
                .dir_i     (port_c_dir_q[g]),
                .pin_i     (PC_I[g]),
                .shared_i  (1'b0),
                .zero_in_i (1'b0),
                .pin_o     (c_pin[g]),
                .pin_oe_o  (c_oe[g]),
                .read_o    (c_rd[g])
            );                                             // see R08
        end
    endgenerate

    // Clock-out replaces pin C2 drive; system clock gated by enable
    // The clock passes as data to the pad only; nothing inside samples it
    assign PC_O    = c_clk[sgpbcd_pkg::CLK_PIN_POS] ?
                     ((c_pin & ~c_clk) | ({6{MCLK_I}} & c_clk)) : c_pin;      // see R09
    assign PC_OE_O = c_oe | c_clk;                                            // see R10

    // Read multiplexer; unmapped addresses read zero
    always_comb begin
        rdata_d = 8'h00;
        unique case (ADDR_I)
            sgpbcd_pkg::OFS_B_DATA: rdata_d = 8'(b_rd);
            sgpbcd_pkg::OFS_C_DATA: rdata_d = {2'h0, c_rd};                   // see R16
            sgpbcd_pkg::OFS_D_DATA: rdata_d = 8'(d_rd);
            sgpbcd_pkg::OFS_B_DIR:  rdata_d = 8'(port_b_dir_q);
            sgpbcd_pkg::OFS_C_DIR:  rdata_d = {sys_clock_out_en_q, 1'b0, port_c_dir_q}; // see R16
            sgpbcd_pkg::OFS_D_DIR:  rdata_d = 8'(port_d_dir_q);
            default:                rdata_d = 8'h00;
        endcase
    end

    // Data latches, no reset, always writable
    // Software must load a latch before turning its pin to output
    always_ff @(posedge MCLK_I) begin
        if (wr_b_data) port_b_latch_q <= WDATA_I[WIDTH-1:0];                  // see R06
        if (wr_c_data) port_c_latch_q <= WDATA_I[5:0];                        // see R07
        if (wr_d_data) port_d_latch_q <= WDATA_I[WIDTH-1:0];                  // see R06
    end

    // Direction registers, cleared by reset
    always_ff @(posedge MCLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            port_b_dir_q       <= sgpbcd_pkg::DIR_RESET[WIDTH-1:0];           // see R04
            port_c_dir_q       <= sgpbcd_pkg::DIR_RESET[5:0];                 // see R04
            sys_clock_out_en_q <= 1'b0;                                       // see R10
            port_d_dir_q       <= sgpbcd_pkg::DIR_RESET[WIDTH-1:0];           // see R04
        end else begin
            if (wr_b_dir) port_b_dir_q <= WDATA_I[WIDTH-1:0];
            if (wr_c_dir) begin
                port_c_dir_q       <= WDATA_I[5:0];
                sys_clock_out_en_q <= WDATA_I[sgpbcd_pkg::CLK_OUT_POS];       // see R09
            end
            if (wr_d_dir) port_d_dir_q <= WDATA_I[WIDTH-1:0];
        end
    end

    // Read data register, valid the cycle after the strobe
    // Returns to zero between reads so a stale byte never looks fresh
    always_ff @(posedge MCLK_I or negedge RESETN_I) begin
        if (!RESETN_I) RDATA_O <= 8'h00;
        else if (RD_I) RDATA_O <= rdata_d;
        else           RDATA_O <= 8'h00;
    end

    // Checks on register writes, read-back and pin ownership

    // Direction write reaches the port B enables, converter pin stays off
    a_dir_drive: assert property (@(posedge MCLK_I) disable iff (!RESETN_I) // see R03
        wr_b_dir |=> PB_OE_O == ($past(WDATA_I[WIDTH-1:0]) & ~b_conv))
        else $error("Port B enable wrong");

    // Converter-owned port B input reads zero
    a_conv_zero: assert property (@(posedge MCLK_I) disable iff (!RESETN_I) // see R01
        rd_b_data && b_hit && !port_b_dir_q[CONV_SEL_I[2:0]] |=> RDATA_O[$past(CONV_SEL_I[2:0])] == 1'b0)
        else $error("Converter bit not zero");

    // Converter-owned port D input reads zero
    a_d_conv_zero: assert property (@(posedge MCLK_I) disable iff (!RESETN_I) // see R01
        rd_d_data && d_hit && !port_d_dir_q[d_off[2:0]] |=> RDATA_O[$past(d_off[2:0])] == 1'b0)
        else $error("Port D converter bit not zero");

    // Converter-owned port B pin never driven
    a_conv_b_float: assert property (@(posedge MCLK_I) disable iff (!RESETN_I) // see R02
        b_hit |-> !PB_OE_O[CONV_SEL_I[2:0]])
        else $error("Converter pin on port B driven");

    // Converter-owned port D pin never driven
    a_conv_d_float: assert property (@(posedge MCLK_I) disable iff (!RESETN_I) // see R11
        d_hit |-> !PD_OE_O[d_off[2:0]])
        else $error("Converter pin on port D driven");

    // All enables low on the first edge after reset
    a_dir_reset: assert property (@(posedge MCLK_I) // see R04
        $rose(RESETN_I) |-> PB_OE_O == '0 && PC_OE_O == '0 && PD_OE_O == '0)
        else $error("Pin driven after reset");

    // Port B output bits read back the latch
    a_out_read: assert property (@(posedge MCLK_I) disable iff (!RESETN_I) // see R05
        rd_b_data && port_b_dir_q == '1 |=> RDATA_O == 8'($past(port_b_latch_q)))
        else $error("Output bit did not read latch");

    // Input bits of port C read the live pin
    a_c_in_read: assert property (@(posedge MCLK_I) disable iff (!RESETN_I) // see R05
        rd_c_data && port_c_dir_q == '0 && !sys_clock_out_en_q |=> RDATA_O == {2'h0, $past(PC_I)})
        else $error("Input bit did not read pin");

    // Read data falls back to zero between reads
    a_rdata_idle: assert property (@(posedge MCLK_I) disable iff (!RESETN_I) // see R05
        !RD_I |=> RDATA_O == 8'h00)
        else $error("Read data not idle");

    // Port B data writes always land in the latch
    a_b_latch: assert property (@(posedge MCLK_I) disable iff (!RESETN_I) // see R06
        wr_b_data |=> port_b_latch_q == $past(WDATA_I[WIDTH-1:0]))
        else $error("Port B latch write lost");

    // Port D data writes always land in the latch
    a_latch_write: assert property (@(posedge MCLK_I) disable iff (!RESETN_I) // see R06
        wr_d_data |=> port_d_latch_q == $past(WDATA_I[WIDTH-1:0]))
        else $error("Latch write lost");

    // Port C data writes land in the six latches
    a_c_latch: assert property (@(posedge MCLK_I) disable iff (!RESETN_I) // see R08
        wr_c_data |=> port_c_latch_q == $past(WDATA_I[5:0]))
        else $error("Port C latch write lost");

    // Clock-out pin always driven while enabled
    a_clk_out_oe: assert property (@(posedge MCLK_I) disable iff (!RESETN_I) // see R10
        sys_clock_out_en_q |-> PC_OE_O[sgpbcd_pkg::CLK_PIN_POS])
        else $error("Clock pin not driven");

    // Clock shows high on pin C2 during the high phase
    a_clk_pin_data: assert property (@(negedge MCLK_I) disable iff (!RESETN_I) // see R09
        sys_clock_out_en_q |-> PC_O[sgpbcd_pkg::CLK_PIN_POS])
        else $error("Clock not on pin");

    // Clock-out enable reads back in its own bit
    a_clk_en_read: assert property (@(posedge MCLK_I) disable iff (!RESETN_I) // see R10
        rd_c_dir |=> RDATA_O[sgpbcd_pkg::CLK_OUT_POS] == $past(sys_clock_out_en_q))
        else $error("Clock enable read wrong");

    // Unimplemented port C data bits read zero
    a_c_unused: assert property (@(posedge MCLK_I) disable iff (!RESETN_I) // see R16
        rd_c_data |=> (RDATA_O & ~sgpbcd_pkg::C_DATA_MASK) == 8'h00)
        else $error("Unused C bits set");

    // Unused port C direction bit reads zero
    a_c_dir_gap: assert property (@(posedge MCLK_I) disable iff (!RESETN_I) // see R16
        rd_c_dir |=> (RDATA_O & ~sgpbcd_pkg::C_DIR_MASK) == 8'h00)
        else $error("Unused C direction bit set");

    // Unmapped addresses read zero
    a_unmapped_zero: assert property (@(posedge MCLK_I) disable iff (!RESETN_I) // see R15
        RD_I && !rd_mapped |=> RDATA_O == 8'h00)
        else $error("Unmapped read not zero");

    // Port B direction reads back at its address
    a_b_dir_read: assert property (@(posedge MCLK_I) disable iff (!RESETN_I) // see R15
        rd_b_dir |=> RDATA_O == 8'($past(port_b_dir_q)))
        else $error("Port B direction read wrong");

    // Port D direction reads back at its address
    a_d_dir_read: assert property (@(posedge MCLK_I) disable iff (!RESETN_I) // see R15
        rd_d_dir |=> RDATA_O == 8'($past(port_d_dir_q)))
        else $error("Port D direction read wrong");

    // Timer A clock pin never driven while selected
    a_timer_hiz: assert property (@(posedge MCLK_I) disable iff (!RESETN_I) // see R13
        ta_sel |-> !PD_OE_O[sgpbcd_pkg::TA_CLK_POS])
        else $error("Timer pin driven");

    // Timer B clock pin never driven while selected
    a_timer_b_hiz: assert property (@(posedge MCLK_I) disable iff (!RESETN_I) // see R13
        tb_sel |-> !PD_OE_O[sgpbcd_pkg::TB_CLK_POS])
        else $error("Timer B pin driven");

    // Both timer clocks held low while neither timer is selected
    a_ext_clk_idle: assert property (@(posedge MCLK_I) disable iff (!RESETN_I) // see R13
        !ta_sel && !tb_sel |-> !TA_EXT_CLK_O && !TB_EXT_CLK_O)
        else $error("Timer clock leaks");

    // Timer-owned input bit reads zero
    a_timer_zero: assert property (@(posedge MCLK_I) disable iff (!RESETN_I) // see R12
        rd_d_data && ta_sel && !port_d_dir_q[sgpbcd_pkg::TA_CLK_POS] |=> RDATA_O[sgpbcd_pkg::TA_CLK_POS] == 1'b0)
        else $error("Timer bit not zero");
endmodule : sgpbcd_top

// >>> tb/sgpbcd_pins.sv
// Pin-side model: an outside source drives each pin unless the port buffer does
`timescale 1ns/1ps
module sgpbcd_pins #(
    parameter int unsigned W = 8        // Pin count
) (
    input  wire logic [W-1:0] drv_i,    // Port drive value
    input  wire logic [W-1:0] oe_i,     // Port buffer enables
    input  wire logic [W-1:0] ext_i,    // Outside source level
    output wire logic [W-1:0] pin_o     // Resolved pin level
);
    // Driven bits follow the port, floating bits the outside source
    assign pin_o = (oe_i & drv_i) | (~oe_i & ext_i);
endmodule : sgpbcd_pins

// >>> tb/shared_gpio_ports_bcd_test.sv
// Self-checking bench for the B/C/D port block
`timescale 1ns/1ps
module shared_gpio_ports_bcd_test;
    typedef struct {logic [3:0] wa; logic [7:0] wd; logic [3:0] ra; logic [7:0] e;} sgpbcd_row_s;
    logic       mclk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, cen = 1'b0, ta_clk, tb_clk; // Bus and control
    logic [3:0] addr = 4'h0;                                       // Register address
    logic [4:0] csel = 5'h00;                                      // Converter channel
    logic [2:0] tap = 3'h0, tbp = 3'h0;                            // Timer prescale codes
    logic [7:0] wdata = 8'h00, rdata, pb_ext = 8'h5a, pd_ext = 8'hc3, pb_i, pb_o, pb_oe, pd_i, pd_o, pd_oe;
    logic [5:0] pc_ext = 6'h15, pc_i, pc_o, pc_oe;                 // Port C pins
    int         error_cnt = 0, tests_run = 0, cyc = 0;             // Counters
    // Write then read rows; data written before direction goes to output
    sgpbcd_row_s rows [9] = '{'{4'h1, 8'ha5, 4'h1, 8'h5a}, '{4'h5, 8'hff, 4'h1, 8'ha5},
        '{4'h3, 8'h3c, 4'h3, 8'hc3}, '{4'h7, 8'hff, 4'h3, 8'h3c}, '{4'h2, 8'h2a, 4'h2, 8'h15},
        '{4'h6, 8'h7f, 4'h2, 8'h2a}, '{4'h6, 8'h7f, 4'h6, 8'h3f}, '{4'h0, 8'hff, 4'h0, 8'h00},
        '{4'h9, 8'hff, 4'h4, 8'h00}};
    sgpbcd_top dut_u (.MCLK_I(mclk), .RESETN_I(rstn), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
        .RDATA_O(rdata), .CONV_SEL_I(csel), .CONV_EN_I(cen), .TA_PS_I(tap), .TB_PS_I(tbp), .PB_I(pb_i),
        .PB_O(pb_o), .PB_OE_O(pb_oe), .PC_I(pc_i), .PC_O(pc_o), .PC_OE_O(pc_oe), .PD_I(pd_i), .PD_O(pd_o),
        .PD_OE_O(pd_oe), .TA_EXT_CLK_O(ta_clk), .TB_EXT_CLK_O(tb_clk));
    sgpbcd_pins #(.W(8)) pins_b (.drv_i(pb_o), .oe_i(pb_oe), .ext_i(pb_ext), .pin_o(pb_i));
    sgpbcd_pins #(.W(6)) pins_c (.drv_i(pc_o), .oe_i(pc_oe), .ext_i(pc_ext), .pin_o(pc_i));
    sgpbcd_pins #(.W(8)) pins_d (.drv_i(pd_o), .oe_i(pd_oe), .ext_i(pd_ext), .pin_o(pd_i));
    // 25 MHz clock
    initial begin
        forever #20 mclk = ~mclk;
    end
    // Compare and count
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        tests_run++;
        if (s !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    // One-cycle write strobe
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask : wr_reg
    // One-cycle read strobe, data checked in the following cycle
    task automatic rd_chk(input string n, input logic [3:0] a, input logic [7:0] e);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 chk(n, rdata, e);
    endtask : rd_chk
    // Verdict and end of run
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop
    // Hang guard
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            report_and_stop();
        end
    end
    // Main sequence
    initial begin
        repeat (3) @(posedge mclk);
        rstn <= 1'b1;
        rd_chk("dir b", 4'h5, 8'h00);
        rd_chk("dir c", 4'h6, 8'h00);
        rd_chk("dir d", 4'h7, 8'h00);
        chk("oe d", pd_oe, 8'h00);
        foreach (rows[i]) begin
            wr_reg(rows[i].wa, rows[i].wd);
            rd_chk("row read", rows[i].ra, rows[i].e);
        end
        rd_chk("b latch", 4'h1, 8'ha5);
        @(posedge mclk);
        #1 chk("rdata idle", rdata, 8'h00);
        chk("pb drive", pb_o & pb_oe, 8'ha5);
        chk("pc drive", {2'h0, pc_o & pc_oe}, 8'h2a);
        chk("pd drive", pd_o & pd_oe, 8'h3c);
        // Converter owns B1 and then D2
        @(posedge mclk);
        cen <= 1'b1;
        csel <= 5'h01;
        pb_ext <= 8'hff;
        pd_ext <= 8'hff;
        rd_chk("conv b out", 4'h1, 8'ha5);
        chk("conv b oe", pb_oe, 8'hfd);
        wr_reg(4'h5, 8'h00);
        rd_chk("conv b in", 4'h1, 8'hfd);
        @(posedge mclk);
        csel <= 5'h0a;
        wr_reg(4'h7, 8'h00);
        rd_chk("conv d in", 4'h3, 8'hfb);
        // Both timers take their clock pins
        @(posedge mclk);
        cen <= 1'b0;
        tap <= 3'h7;
        tbp <= 3'h7;
        wr_reg(4'h7, 8'hff);
        #1 chk("timer oe", pd_oe, 8'haf);
        chk("timer clocks", {6'h0, ta_clk, tb_clk}, 8'h03);
        wr_reg(4'h7, 8'h00);
        rd_chk("timer in", 4'h3, 8'haf);
        // Clock out on C2 overrides its direction bit
        wr_reg(4'h6, 8'h80);
        rd_chk("clk en", 4'h6, 8'h80);
        chk("clk oe", {7'h0, pc_oe[2]}, 8'h01);
        chk("clk hi", {7'h0, pc_o[2]}, 8'h01);
        #25 chk("clk lo", {7'h0, pc_o[2]}, 8'h00);
        // Mid-run reset keeps port C latches
        @(posedge mclk);
        rstn <= 1'b0;
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        chk("oe c reset", {2'h0, pc_oe}, 8'h00);
        rd_chk("dir c reset", 4'h6, 8'h00);
        wr_reg(4'h6, 8'h3f);
        rd_chk("c latch kept", 4'h2, 8'h2a);
        report_and_stop();
    end
endmodule : shared_gpio_ports_bcd_test
